// ### rtl/cdcw_pkg.sv
/*
 Constants shared by the coil drive control word decoder: command field
 positions, register select codes, reset values and step timing.
 Assumes a 50 MHz system clock and 20-bit serial commands.
*/
package cdcw_pkg;
	// Serial command framing
	localparam int WORD_W = 20;
	localparam int SEL_HI = 19;
	localparam int SEL_LO = 18;
	localparam int CONF_SEL_LO = 17;
	localparam logic [1:0] SEL_DRIVER_CONTROL = 2'h0;
	localparam logic [2:0] SEL_DRIVER_CONFIG = 3'h7;
	localparam int STEP_OFF_BIT = 7;

	// Direct-current layout
	localparam int COIL_A_POL_BIT = 17;
	localparam int COIL_A_MAG_MSB = 16;
	localparam int COIL_A_MAG_LSB = 9;
	localparam int COIL_B_POL_BIT = 8;
	localparam int COIL_B_MAG_MSB = 7;
	localparam int COIL_B_MAG_LSB = 0;
	localparam int MAG_W = 8;

	// Step/direction layout
	localparam int INTERP_BIT = 9;
	localparam int DUAL_EDGE_BIT = 8;
	localparam int MICROSTEP_RESOLUTION_MSB = 3;
	localparam int MICROSTEP_RESOLUTION_LSB = 0;
	localparam int MICROSTEP_RESOLUTION_W = 4;
	localparam logic [3:0] MICROSTEP_RESOLUTION_FULL = 4'h8;
	localparam logic [3:0] INTERP_MIN_CODE = 4'h4;
	localparam logic [4:0] INTERP_SUBSTEPS = 5'h10;

	// Reset values
	localparam logic [WORD_W-1:0] SHIFT_RST = 20'h00000;
	localparam logic STEP_OFF_RST = 1'b0;
	localparam logic [MAG_W-1:0] MAG_RST = 8'h00;
	localparam logic [MICROSTEP_RESOLUTION_W-1:0] MICROSTEP_RESOLUTION_RST = 4'h0;

	// Microstep position: 256 per quarter period, 1024 per electrical period
	localparam int POS_W = 10;
	localparam logic [POS_W-1:0] POS_RST = 10'h000;

	// Spacing of interpolated microsteps
	localparam int CLK_PERIOD_NS = 20;
	localparam int INTERP_GAP_NS = 200;
	localparam int INTERP_GAP_CYC = (INTERP_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int GAP_W = 8;
	localparam logic [GAP_W-1:0] GAP_LAST = GAP_W'(INTERP_GAP_CYC - 1);
endpackage

// ### rtl/cdcw_step_if.sv
/*
 Carrier between the decoder top and the step sequencer: qualified step
 events, direction and step configuration in, microstep position out.
 Assumes both ends run on the system clock.
*/
`timescale 1ns/1ps
interface cdcw_step_if;
	import cdcw_pkg::*;
	logic stepPulse;
	logic stepDir;
	logic stepInterpolateEn;
	logic [MICROSTEP_RESOLUTION_W-1:0] microstepResolution;
	logic [POS_W-1:0] position;
	modport ctrl (output stepPulse, stepDir, stepInterpolateEn, microstepResolution,
		input position);
	modport seq (input stepPulse, stepDir, stepInterpolateEn, microstepResolution,
		output position);
endinterface

// ### rtl/cdcw_step_seq.sv
/*
 Step sequencer: advances a 10-bit microstep position on each qualified
 step event, by the step size that the resolution code gives, optionally
 split into 16 evenly spaced interpolated microsteps for codes 4 and up.
 Assumes step events are single-cycle pulses on the system clock.
*/
`timescale 1ns/1ps
module cdcw_step_seq (
	input wire logic sys_clk,
	input wire logic sys_rst,
	cdcw_step_if.seq stepIf
);
	import cdcw_pkg::*;

	logic [POS_W-1:0] posQ;
	logic [POS_W-1:0] targetQ;
	logic [POS_W-1:0] subQ;
	logic [4:0] remQ;
	logic [GAP_W-1:0] gapQ;
	logic dirQ;
	logic [MICROSTEP_RESOLUTION_W-1:0] codeNow;
	logic [POS_W-1:0] targetD;
	logic splitNow;

	// Codes above full step act as full step
	function automatic logic [MICROSTEP_RESOLUTION_W-1:0] clampCode(input logic [MICROSTEP_RESOLUTION_W-1:0] code);
		return (code > MICROSTEP_RESOLUTION_FULL) ? MICROSTEP_RESOLUTION_FULL : code;
	endfunction

	// Signed move on the wrapping position circle; direction high counts down
	function automatic logic [POS_W-1:0] movePos(input logic [POS_W-1:0] base,
		input logic [POS_W-1:0] amount, input logic down);
		return down ? POS_W'(base - amount) : POS_W'(base + amount);
	endfunction

	assign codeNow = clampCode(stepIf.microstepResolution);
	// Finer than 16 per quarter leaves nothing to interpolate
	assign splitNow = stepIf.stepInterpolateEn && (codeNow >= INTERP_MIN_CODE);
	// A new step starts from the previous target so no motion is lost
	assign targetD = movePos(targetQ, POS_W'(10'h001 << codeNow), stepIf.stepDir);

	// Position, target and interpolation progress
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			posQ <= POS_RST;
			targetQ <= POS_RST;
			subQ <= POS_RST;
			remQ <= 5'h00;
			gapQ <= 8'h00;
			dirQ <= 1'b0;
		end else if (stepIf.stepPulse) begin
			targetQ <= targetD;
			dirQ <= stepIf.stepDir;
			gapQ <= 8'h00;
			if (splitNow) begin
				subQ <= POS_W'(10'h001 << (codeNow - INTERP_MIN_CODE));
				posQ <= movePos(targetQ, POS_W'(10'h001 << (codeNow - INTERP_MIN_CODE)),
					stepIf.stepDir);
				remQ <= 5'(INTERP_SUBSTEPS - 5'h01);
			end else begin
				posQ <= targetD;
				remQ <= 5'h00;
			end
		end else if (remQ != 5'h00) begin
			if (gapQ == GAP_LAST) begin
				gapQ <= 8'h00;
				posQ <= movePos(posQ, subQ, dirQ);
				remQ <= 5'(remQ - 5'h01);
			end else begin
				gapQ <= 8'(gapQ + 8'h01);
			end
		end
	end

	assign stepIf.position = posQ;
endmodule

// ### rtl/cdcw_top.sv
/*
 Coil drive control word decoder. A serial shift register on the link
 clock collects commands; on the rising edge of chip select the system
 domain decodes the last 20 bits, tracks the step-interface-off bit of
 the driver configuration command and stores the driver control word in
 the layout that bit selects. Step and direction pins feed a sequencer.
 Assumes the host holds the serial clock still for at least three system
 clocks after chip select rises, so the shift register is stable when read.
*/
// What this block does
// - Layout chosen by current step-interface-off bit
// - Interface off: ignore step, currents from word
// - Interface on: step pins act, word configures
// - Bit 17 gives coil A polarity
// - Bits 16..9 give coil A magnitude
// - Bit 8 gives coil B polarity
// - Bits 7..0 give coil B magnitude
// - Bit 9 enables sixteenfold step interpolation for resolution codes 4 and up
// - Bit 8 makes both step edges active
// - Bits 3..0 pick microsteps per quarter
// - Top bits zero select driver control word
// - Latch last 20 bits at select rise
`timescale 1ns/1ps
module cdcw_top (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic spiClk,
	input wire logic chipSelectLow_n,
	input wire logic serialDataIn,
	input wire logic stepIn,
	input wire logic dirIn,
	output logic stepInterfaceOff,
	output logic coilAPolarity,
	output logic [cdcw_pkg::MAG_W-1:0] coilAMagnitude,
	output logic coilBPolarity,
	output logic [cdcw_pkg::MAG_W-1:0] coilBMagnitude,
	output logic stepInterpolateEn,
	output logic dualEdgeStep,
	output logic [cdcw_pkg::MICROSTEP_RESOLUTION_W-1:0] microstepResolution,
	output logic [cdcw_pkg::POS_W-1:0] microstepPosition,
	output logic wordLatched
);
	import cdcw_pkg::*;

	logic [WORD_W-1:0] shiftQ;
	logic selSync1Q;
	logic selSync2Q;
	logic selPrevQ;
	logic latchNow;
	logic isControl;
	logic isConfig;
	logic stepOffQ;
	logic coilAPolQ;
	logic [MAG_W-1:0] coilAMagQ;
	logic coilBPolQ;
	logic [MAG_W-1:0] coilBMagQ;
	logic interpQ;
	logic dualEdgeQ;
	logic [MICROSTEP_RESOLUTION_W-1:0] mresQ;
	logic latchedQ;
	logic stepSync1Q;
	logic stepSync2Q;
	logic stepPrevQ;
	logic dirSync1Q;
	logic dirSync2Q;
	logic stepRise;
	logic stepFall;

	cdcw_step_if stepIf ();

	// Link domain: shift while selected; older bits fall off the top,
	// so any longer frame leaves only its last 20 bits
	always_ff @(posedge spiClk or posedge sys_rst) begin
		if (sys_rst) begin
			shiftQ <= SHIFT_RST;
		end else if (!chipSelectLow_n) begin
			shiftQ <= {shiftQ[WORD_W-2:0], serialDataIn};
		end
	end

	// Chip select into the system domain, then edge detect on the second stage
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			selSync1Q <= 1'b1;
			selSync2Q <= 1'b1;
			selPrevQ <= 1'b1;
		end else begin
			selSync1Q <= chipSelectLow_n;
			selSync2Q <= selSync1Q;
			selPrevQ <= selSync2Q;
		end
	end

	// The word is quasi-static here: the serial clock stands while deselected
	assign latchNow = selSync2Q && !selPrevQ;

	// Register select from the top bits of the frame
	assign isControl = shiftQ[SEL_HI:SEL_LO] == SEL_DRIVER_CONTROL;
	assign isConfig = shiftQ[SEL_HI:CONF_SEL_LO] == SEL_DRIVER_CONFIG;

	// Step-interface-off bit from the driver configuration command
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			stepOffQ <= STEP_OFF_RST;
		end else if (latchNow && isConfig) begin
			stepOffQ <= shiftQ[STEP_OFF_BIT];
		end
	end

	// Direct-current layout, stored only while the step interface is off
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			coilAPolQ <= 1'b0;
			coilAMagQ <= MAG_RST;
			coilBPolQ <= 1'b0;
			coilBMagQ <= MAG_RST;
		end else if (latchNow && isControl && stepOffQ) begin
			coilAPolQ <= shiftQ[COIL_A_POL_BIT];
			coilAMagQ <= shiftQ[COIL_A_MAG_MSB:COIL_A_MAG_LSB];
			coilBPolQ <= shiftQ[COIL_B_POL_BIT];
			coilBMagQ <= shiftQ[COIL_B_MAG_MSB:COIL_B_MAG_LSB];
		end
	end

	// Step/direction layout; reserved bits are not looked at, the host
	// writes them as zero, and no clamping of magnitudes is done here
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			interpQ <= 1'b0;
			dualEdgeQ <= 1'b0;
			mresQ <= MICROSTEP_RESOLUTION_RST;
		end else if (latchNow && isControl && !stepOffQ) begin
			interpQ <= shiftQ[INTERP_BIT];
			dualEdgeQ <= shiftQ[DUAL_EDGE_BIT];
			mresQ <= shiftQ[MICROSTEP_RESOLUTION_MSB:MICROSTEP_RESOLUTION_LSB];
		end
	end

	// One-cycle flag each time a driver control word is accepted
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			latchedQ <= 1'b0;
		end else begin
			latchedQ <= latchNow && isControl;
		end
	end

	// Step and direction pins pass two flip-flops; edges use the second stage
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			stepSync1Q <= 1'b0;
			stepSync2Q <= 1'b0;
			stepPrevQ <= 1'b0;
			dirSync1Q <= 1'b0;
			dirSync2Q <= 1'b0;
		end else begin
			stepSync1Q <= stepIn;
			stepSync2Q <= stepSync1Q;
			stepPrevQ <= stepSync2Q;
			dirSync1Q <= dirIn;
			dirSync2Q <= dirSync1Q;
		end
	end

	assign stepRise = stepSync2Q && !stepPrevQ;
	assign stepFall = !stepSync2Q && stepPrevQ;

	// Step events reach the sequencer only while the interface is on
	assign stepIf.stepPulse = !stepOffQ && (stepRise || (dualEdgeQ && stepFall));
	assign stepIf.stepDir = dirSync2Q;
	assign stepIf.stepInterpolateEn = interpQ;
	assign stepIf.microstepResolution = mresQ;

	cdcw_step_seq stepSeq (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.stepIf(stepIf)
	);

	// Outputs straight from registers
	assign stepInterfaceOff = stepOffQ;
	assign coilAPolarity = coilAPolQ;
	assign coilAMagnitude = coilAMagQ;
	assign coilBPolarity = coilBPolQ;
	assign coilBMagnitude = coilBMagQ;
	assign stepInterpolateEn = interpQ;
	assign dualEdgeStep = dualEdgeQ;
	assign microstepResolution = mresQ;
	assign microstepPosition = stepIf.position;
	assign wordLatched = latchedQ;
endmodule

// ### testbench/cdcw_host_model.sv
/*
 Host side model: serial command sender and step/direction pin source.
 Assumes the caller starts each task just after a system clock edge.
*/
`timescale 1ns/1ps
module cdcw_host_model (
	output logic spiClk,
	output logic csLow_n,
	output logic sdi,
	output logic stepPin,
	output logic dirPin
);
	// Idle: link clock still, chip select high
	initial begin
		spiClk = 0;
		csLow_n = 1;
		sdi = 0;
		stepPin = 0;
		dirPin = 0;
	end
	// Extra leading bits fall out; only the last 20 count
	task automatic send(input logic [23:0] w);
		#3 csLow_n = 0;
		for (int i = 23; i >= 0; i--) begin
			sdi = w[i]; // Most significant bit goes first
			#80 spiClk = 1;
			#80 spiClk = 0;
		end
		#40 csLow_n = 1;
		sdi = ~sdi; // Released line: no stale level
		#300;
	endtask
	// Toggle the step pin; spacing well above the sync window
	task automatic step(input logic d);
		dirPin = d;
		#100 stepPin = ~stepPin;
		#200;
	endtask
endmodule

// ### testbench/cdcw_checker.sv
/*
 Assertions on the decoder ports; a shadow shift register rebuilds the
 frame. Assumes spiClk is still while the word is latched.
*/
`timescale 1ns/1ps
module cdcw_checker import cdcw_pkg::*; (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic spiClk,
	input wire logic chipSelectLow_n,
	input wire logic serialDataIn,
	input wire logic stepInterfaceOff,
	input wire logic coilAPolarity,
	input wire logic [MAG_W-1:0] coilAMagnitude,
	input wire logic coilBPolarity,
	input wire logic [MAG_W-1:0] coilBMagnitude,
	input wire logic stepInterpolateEn,
	input wire logic dualEdgeStep,
	input wire logic [MICROSTEP_RESOLUTION_W-1:0] microstepResolution,
	input wire logic [POS_W-1:0] microstepPosition,
	input wire logic wordLatched
);
	logic [19:0] sh_q;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	// Shadow of the serial shifter
	always_ff @(posedge spiClk or posedge sys_rst) begin
		if (sys_rst) sh_q <= 20'h00000;
		else if (!chipSelectLow_n) sh_q <= {sh_q[18:0], serialDataIn};
	end
	AST_SELECT: assert property (wordLatched |-> sh_q[19:18] == 2'h0)
		else $error("latch without control select");
	AST_COIL_A: assert property (wordLatched && stepInterfaceOff |->
		{coilAPolarity, coilAMagnitude} == sh_q[17:9]) else $error("coil A wrong");
	AST_COIL_B: assert property (wordLatched && stepInterfaceOff |->
		{coilBPolarity, coilBMagnitude} == sh_q[8:0]) else $error("coil B wrong");
	AST_STEP_CFG: assert property (wordLatched && !stepInterfaceOff |->
		{stepInterpolateEn, dualEdgeStep, microstepResolution} == {sh_q[9:8], sh_q[3:0]})
		else $error("step config wrong");
	AST_HOLD_COIL: assert property (!(wordLatched && stepInterfaceOff) |->
		$stable({coilAPolarity, coilAMagnitude, coilBPolarity, coilBMagnitude}))
		else $error("coil fields moved");
	AST_HOLD_STEP: assert property (!(wordLatched && !stepInterfaceOff) |->
		$stable({stepInterpolateEn, dualEdgeStep, microstepResolution}))
		else $error("step fields moved");
	AST_LATCH_TIME: assert property ($rose(chipSelectLow_n) && sh_q[19:18] == 2'h0
		|-> ##[1:5] wordLatched) else $error("word not latched in time");
	AST_PULSE: assert property (wordLatched |=> !wordLatched)
		else $error("latch pulse too long");
	AST_STEP_OFF: assert property (stepInterfaceOff |=> $stable(microstepPosition))
		else $error("position moved with interface off");
endmodule
bind cdcw_top cdcw_checker chkr (.*);

// ### testbench/tb_top.sv
/*
 Self-checking bench for the control word decoder against a model.
 Assumes the host model paces frames and steps itself.
*/
`timescale 1ns/1ps
module tb_top;
	import cdcw_pkg::*;
	logic sys_clk = 0;
	logic sys_rst = 1;
	logic [31:0] seed = 43042;
	wire spiClk, csLow_n, sdi, stepPin, dirPin, offQ, latched;
	wire [17:0] coil;
	wire [5:0] cfg;
	wire [POS_W-1:0] pos;
	int miscompares = 0;
	int nChecks = 0;
	int eOff = 0;
	int eCoil = 0;
	int eCfg = 0;
	int ePos = 0;
	cdcw_host_model host (.spiClk(spiClk), .csLow_n(csLow_n), .sdi(sdi),
		.stepPin(stepPin), .dirPin(dirPin));
	cdcw_top dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .spiClk(spiClk),
		.chipSelectLow_n(csLow_n), .serialDataIn(sdi), .stepIn(stepPin), .dirIn(dirPin),
		.stepInterfaceOff(offQ), .coilAPolarity(coil[17]), .coilAMagnitude(coil[16:9]),
		.coilBPolarity(coil[8]), .coilBMagnitude(coil[7:0]), .stepInterpolateEn(cfg[5]),
		.dualEdgeStep(cfg[4]), .microstepResolution(cfg[3:0]), .microstepPosition(pos),
		.wordLatched(latched));
	always #10 sys_clk = ~sys_clk;
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		nChecks++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One frame with random leading junk, then model update and compare
	task automatic put(input logic [19:0] w);
		logic [31:0] r;
		r = rnd();
		@(negedge sys_clk);
		host.send({r[3:0], w});
		if (w[19:17] == 3'h7) eOff = w[STEP_OFF_BIT];
		else if (w[19:18] == 2'h0 && eOff != 0) eCoil = w[17:0];
		else if (w[19:18] == 2'h0) eCfg = {w[9:8], w[3:0]};
		chk(offQ, eOff);
		chk(coil, eCoil);
		chk(cfg, eCfg);
	endtask
	// One pin toggle, model moves on active edges only
	task automatic stepIt(input logic d, input int extra);
		int sz;
		@(negedge sys_clk);
		host.step(d);
		sz = 1 << ((eCfg[3:0] > 8) ? 8 : eCfg[3:0]);
		if (eOff == 0 && (stepPin || eCfg[4])) ePos = (d ? ePos - sz : ePos + sz) & 1023;
		repeat (extra) @(negedge sys_clk);
		chk(pos, ePos);
	endtask
	task automatic test_done;
		$display("checks %0d miscompares %0d", nChecks, miscompares);
		if (miscompares == 0 && nChecks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial begin
		#1000000;
		miscompares++;
		test_done;
	end
	initial begin
		logic [31:0] r;
		repeat (8) @(negedge sys_clk);
		sys_rst = 0;
		chk({offQ, coil, cfg, pos, latched}, 0);
		$display("reset test done");
		put(20'he0080);
		// Magnitudes kept within the host limit
		repeat (4) begin
			r = rnd();
			put({2'h0, r[17], 8'(r[16:9] % 249), r[8], 8'(r[7:0] % 249)});
			stepIt(r[20], 0);
		end
		put(20'h9abcd);
		$display("current mode test done");
		put(20'he0000);
		for (int c = 0; c < 16; c++) begin
			for (int de = 0; de < 2; de++) begin
				r = rnd();
				put({10'h0, 1'b0, de[0], 4'h0, c[3:0]});
				stepIt(r[0], 0);
				stepIt(r[1], 0);
			end
		end
		$display("step mode test done");
		put(20'h00208);
		stepIt(1'b0, 200);
		put(20'he0080);
		$display("interpolation test done");
		test_done;
	end
endmodule
